/* iws_consts.vh */
// constants for the interrupt and wait sequencer
`ifndef IWS_CONSTS_VH
`define IWS_CONSTS_VH
// register offsets on the plain register port
`define IWS_OFF_STAT_LOW 4'h0
`define IWS_OFF_STAT_MID 4'h1
`define IWS_OFF_STAT_HIGH 4'h2
`define IWS_OFF_BRK_CTRL 4'h3
`define IWS_OFF_BRK_STAT 4'h4
`define IWS_OFF_ENABLE_LO 4'h5
`define IWS_OFF_ENABLE_HI 4'h6
`define IWS_OFF_WAIT_CFG 4'h7
// field positions
`define IWS_BIT_BREAK_CLEAR_ENABLE 0
`define IWS_BIT_BREAK_STOP_WAIT_STATUS 1
`define IWS_BIT_WDOG_DIS 0
// reset values
`define IWS_RST_ENABLE 8'h00
`define IWS_RST_BRK_CTRL 8'h00
`define IWS_RST_WDOG_DIS 1'b0
// vector addresses
`define IWS_VEC_RESET 16'hfffe
`define IWS_VEC_TRAP 16'hfffc
`define IWS_VEC_BASE 16'hfffa
`define IWS_VEC_NONE 16'h0000
// number of maskable sources, flag index 1 to 15
`define IWS_NSRC 15
// cycles from wake request to stacking start
`define IWS_WAKE_DELAY 2'h1
`endif

/* iws_sequencer.v */
// interrupt arbitration, break entry, flag protection and wait sequencing
//
// Notes on behaviour
// - arbitrate only at instruction boundary
// - service needs mask clear and source enable
// - highest fixed priority wins
// - pending request serviced before next instruction
// - upper index register never stacked
// - software trap ignores global mask
// - trap stacks pc, hardware stacks pc minus one
// - global mask gates all but trap; here break and reset ignore it too
// - timer channel 0 flag 3, vector fff6
// - timer channel 2 flag 6, vector fff0
// - converter flag 15, lowest, vector ffde
// - status flag reads one while requested
// - low status bits 0,1,3 read zero
// - resets highest priority, never arbitrated
// - break forces fetch from trap vector
// - break protects flags unless clear enable
// - flag cleared in break stays cleared
// - two-step clear finishes after break
// - wait or stop clears global mask
// - wait stops cpu clock, peripherals run
// - wake stacking starts one cycle later
// - break in wait sets status; watchdog
// - latched request keeps precedence
//
// overview
// - requests are levels from the peripherals
// - taken only at a boundary, a return or wake fire
// - reset taken at once, never latched
// - break taken at once, or held while busy
// - choice held until the core reports entry done; a hardware one drops once the mask is clear and no enabled request is left
// - status reads come one cycle after the strobe
// - enable bits for flags 2 and 8 have no effect
// - clock gating outputs are plain enables
//
// Our own choices: the strobed register port and the address map.
`include "iws_consts.vh"

module iws_sequencer #(
   parameter NSRC = `IWS_NSRC
)(
   // clock and reset
   input wire core_clk,
   input wire reset,
   // register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // peripheral requests, bit i is flag i, bit 0 unused
   input wire [NSRC:0] src_req,
   // processor core handshake
   input wire cpu_boundary,
   input wire cpu_global_mask,
   input wire cpu_trap_instr,
   input wire cpu_wait_instr,
   input wire cpu_stop_instr,
   input wire cpu_rti_done,
   input wire cpu_entry_done,
   input wire any_reset,
   input wire brk_req,
   // peripheral flag clear steps
   input wire flag_clear_req,
   output reg flag_clear_ok,
   // to processor core
   output reg service_req,
   output reg [15:0] vector_addr,
   output reg stack_pc_minus_one,
   output reg stack_upper_index,
   output reg clear_global_mask,
   output reg cpu_clk_en,
   output reg periph_clk_en,
   output reg break_active,
   output reg watchdog_run
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // software controls
   reg [NSRC:1] enable_q;
   reg break_clear_enable_q;
   reg break_stop_wait_status_q;
   reg wdog_dis_q;
   // wait sequencing state
   reg in_wait_q;
   reg [1:0] wake_cnt_q;
   // latched service choice, held until the core takes it or, for a hardware one, the mask is clear and no enabled request is left
   reg latched_q;
   reg latched_trap_q;
   // break seen while another service was latched
   reg brk_pend_q;

   // ----------------------------------------------------------------
   // priority arbitration
   // ----------------------------------------------------------------
   wire [NSRC:1] req_flags;
   wire [NSRC:1] eligible;
   reg [15:0] win_vec;
   reg win_hit;
   wire eligible_any;
   integer i;

   // live request flags, unassigned positions forced low
   genvar g;
   generate
      for (g = 1; g <= NSRC; g = g + 1)
      begin : g_flag
         // flags 2 and 8 have no source
         assign req_flags[g] = (g == 2 || g == 8) ? 1'b0 : src_req[g];
         assign eligible[g] = req_flags[g] & enable_q[g];
      end
   endgenerate

   // any enabled source asking, mask aside
   assign eligible_any = |eligible;

   // ----------------------------------------------------------------
   // status and enable views
   // ----------------------------------------------------------------
   // low byte: flags 6..3 on top, flag 1 at bit 2
   wire [7:0] stat_low = {req_flags[6:3], 1'b0, req_flags[1], 2'b00};
   // middle byte: flags 14..7
   wire [7:0] stat_mid = req_flags[14:7];
   // high byte: flag 15 alone
   wire [7:0] stat_high = {7'h00, req_flags[15]};
   // enables read back in bits 7:1, flag 8 has none
   wire [7:0] en_low = {enable_q[7:1], 1'b0};
   wire [7:0] en_high = {enable_q[NSRC:9], 1'b0};

   // lowest index wins, vector steps down two per index
   always @*
   begin
      win_hit = 1'b0;
      win_vec = `IWS_VEC_NONE;
      // walk down so the lowest index lands last
      for (i = NSRC; i >= 1; i = i - 1)
      begin
         if (eligible[i])
         begin
            win_hit = 1'b1;
            // flag 3 gives fff6, 6 gives fff0, 15 gives ffde
            win_vec = `IWS_VEC_BASE - {i[14:0], 1'b0} + 16'h0002;
         end
      end
   end

   // mask gates hardware requests only
   wire hw_go = win_hit & ~cpu_global_mask;

   // break now or held from an earlier busy cycle
   wire brk_now = brk_req | brk_pend_q;

   // trap and break share the trap vector, mask ignored
   wire trap_go = cpu_trap_instr | brk_now;

   // ----------------------------------------------------------------
   // service latching and vector output
   // ----------------------------------------------------------------
   // wake fires one cycle after the wake event
   wire wake_fire = in_wait_q & (wake_cnt_q == `IWS_WAKE_DELAY);

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         // nothing latched, no vector out of reset
         latched_q <= 1'b0;
         latched_trap_q <= 1'b0;
         service_req <= 1'b0;
         vector_addr <= `IWS_VEC_NONE;
         stack_pc_minus_one <= 1'b0;
         stack_upper_index <= 1'b0;
      end
      else
      begin
         // index high byte is never part of the frame
         stack_upper_index <= 1'b0;
         if (any_reset)
         begin
            // reset outranks everything, no arbitration
            latched_q <= 1'b0;
            latched_trap_q <= 1'b0;
            service_req <= 1'b1;
            vector_addr <= `IWS_VEC_RESET;
            stack_pc_minus_one <= 1'b0;
         end
         else if (latched_q)
         begin
            // hold latched choice until done, or a hardware one until mask clear and nothing eligible
            if (cpu_entry_done)
            begin
               latched_q <= 1'b0;
               service_req <= 1'b0;
            end
            // mask clear and nothing left to serve: let go
            else if (~latched_trap_q && cpu_global_mask == 1'b0 &&
                     ~eligible_any)
            begin
               latched_q <= 1'b0;
               service_req <= 1'b0;
            end
         end
         else if (brk_now || ((cpu_boundary | cpu_rti_done | wake_fire) &&
                  (trap_go | hw_go)))
         begin
            // boundary or return checks pending requests
            // a break needs no boundary, it is forced at once
            latched_q <= 1'b1;
            service_req <= 1'b1;
            if (trap_go)
            begin
               // trap frame holds the pc itself
               latched_trap_q <= 1'b1;
               vector_addr <= `IWS_VEC_TRAP;
               stack_pc_minus_one <= 1'b0;
            end
            else
            begin
               // hardware frame holds pc minus one
               latched_trap_q <= 1'b0;
               vector_addr <= win_vec;
               stack_pc_minus_one <= 1'b1;
            end
         end
         else
         begin
            // nothing taken this cycle
            service_req <= 1'b0;
         end
      end
   end

   // hold a break that arrives while a service is latched
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
         brk_pend_q <= 1'b0;
      else
         brk_pend_q <= brk_now & latched_q & ~any_reset;
   end

   // ----------------------------------------------------------------
   // wait mode sequencing
   // ----------------------------------------------------------------
   // anything that may end wait
   wire wake_ev = (hw_go | any_reset | brk_req);

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         // core and peripheral clocks run out of reset
         in_wait_q <= 1'b0;
         wake_cnt_q <= 2'h0;
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         clear_global_mask <= 1'b0;
      end
      else
      begin
         periph_clk_en <= 1'b1;
         clear_global_mask <= cpu_wait_instr | cpu_stop_instr;
         // enter wait: stop the core clock only
         if (cpu_wait_instr && ~in_wait_q)
         begin
            in_wait_q <= 1'b1;
            cpu_clk_en <= 1'b0;
            wake_cnt_q <= 2'h0;
         end
         else if (in_wait_q)
         begin
            // count from the first wake event
            if (wake_cnt_q != 2'h0 || wake_ev)
               wake_cnt_q <= wake_cnt_q + 2'h1;
            // leave on the fire cycle, or at once on reset
            if (wake_fire || any_reset)
            begin
               in_wait_q <= 1'b0;
               cpu_clk_en <= 1'b1;
               wake_cnt_q <= 2'h0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // break state, flag protection and watchdog
   // ----------------------------------------------------------------
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         // clears allowed, watchdog runs from reset
         break_active <= 1'b0;
         break_stop_wait_status_q <= 1'b0;
         flag_clear_ok <= 1'b1;
         watchdog_run <= 1'b1;
      end
      else
      begin
         // break state from break request until return
         if (brk_req)
            break_active <= 1'b1;
         else if (cpu_rti_done)
            break_active <= 1'b0;
         // set wins over software clear
         if (brk_req && in_wait_q)
            break_stop_wait_status_q <= 1'b1;
         else if (reg_wr && reg_addr == `IWS_OFF_BRK_STAT &&
                  ~reg_wdata[`IWS_BIT_BREAK_STOP_WAIT_STATUS])
            break_stop_wait_status_q <= 1'b0;
         // protected break blocks every clear step, first or second
         flag_clear_ok <= ~(break_active | brk_req) | break_clear_enable_q;
         // a clear that went through is never undone here
         watchdog_run <= ~wdog_dis_q;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // software writes; flag status registers ignore writes, break status is cleared in the break block
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         // all sources disabled, protection on
         enable_q <= {NSRC{1'b0}};
         break_clear_enable_q <= 1'b0;
         wdog_dis_q <= `IWS_RST_WDOG_DIS;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            // break clear enable
            `IWS_OFF_BRK_CTRL: break_clear_enable_q <= reg_wdata[`IWS_BIT_BREAK_CLEAR_ENABLE];
            // enables for flags 1..7
            `IWS_OFF_ENABLE_LO: enable_q[7:1] <= reg_wdata[7:1];
            // enables for flags 9..15, flag 8 has no source
            `IWS_OFF_ENABLE_HI: enable_q[NSRC:9] <= reg_wdata[7:1];
            // watchdog disable
            `IWS_OFF_WAIT_CFG: wdog_dis_q <= reg_wdata[`IWS_BIT_WDOG_DIS];
            default: break_clear_enable_q <= break_clear_enable_q;
         endcase
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            // live request flags, bits 0,1,3 of low read zero
            `IWS_OFF_STAT_LOW: reg_rdata <= stat_low;
            `IWS_OFF_STAT_MID: reg_rdata <= stat_mid;
            `IWS_OFF_STAT_HIGH: reg_rdata <= stat_high;
            // break controls and status
            `IWS_OFF_BRK_CTRL: reg_rdata <= {7'h00, break_clear_enable_q};
            `IWS_OFF_BRK_STAT: reg_rdata <= {6'h00, break_stop_wait_status_q, 1'b0};
            // enables and watchdog config
            `IWS_OFF_ENABLE_LO: reg_rdata <= en_low;
            `IWS_OFF_ENABLE_HI: reg_rdata <= en_high;
            `IWS_OFF_WAIT_CFG: reg_rdata <= {7'h00, wdog_dis_q};
            // unmapped offsets read zero
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

endmodule // iws_sequencer

/* iws_sequencer_sva.sv */
// port checker for the interrupt and wait sequencer
module iws_sequencer_sva (
   // clock and reset
   input wire core_clk,
   input wire reset,
   // register port
   input wire [3:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // core handshake
   input wire cpu_boundary,
   input wire cpu_global_mask,
   input wire cpu_trap_instr,
   input wire cpu_wait_instr,
   input wire cpu_stop_instr,
   input wire cpu_entry_done,
   input wire any_reset,
   // sequencer outputs
   input wire service_req,
   input wire [15:0] vector_addr,
   input wire stack_pc_minus_one,
   input wire stack_upper_index,
   input wire clear_global_mask,
   input wire cpu_clk_en,
   input wire periph_clk_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // service entry
   property p_rst; any_reset |=> service_req && vector_addr == 16'hfffe;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset vector not presented");
   property p_trap; cpu_boundary && cpu_trap_instr && !service_req
      && !any_reset |=> service_req && vector_addr == 16'hfffc
      && !stack_pc_minus_one; endproperty
   a_trap: assert property (p_trap)
      else $error("trap entry wrong");
   property p_mask; $rose(service_req) && stack_pc_minus_one
      |-> !$past(cpu_global_mask); endproperty
   a_mask: assert property (p_mask)
      else $error("masked request serviced");
   property p_hold; service_req && !cpu_entry_done && !any_reset
      |=> !service_req || $stable(vector_addr); endproperty
   a_hold: assert property (p_hold)
      else $error("latched vector changed");
   property p_upper; stack_upper_index == 1'b0; endproperty
   a_upper: assert property (p_upper)
      else $error("upper index stacked");
   // low power
   property p_wait; cpu_wait_instr |=> !cpu_clk_en && clear_global_mask;
   endproperty
   a_wait: assert property (p_wait)
      else $error("wait entry wrong");
   property p_stop; cpu_stop_instr |=> clear_global_mask; endproperty
   a_stop: assert property (p_stop)
      else $error("stop left mask set");
   property p_periph; periph_clk_en; endproperty
   a_periph: assert property (p_periph)
      else $error("peripheral clock stopped");
   // register reads
   property p_low; reg_rd && reg_addr == 4'h0
      |=> (reg_rdata & 8'h0b) == 8'h00; endproperty
   a_low: assert property (p_low)
      else $error("fixed zero bits set");
   property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle)
      else $error("read data outside read cycle");
endmodule // iws_sequencer_sva

bind iws_sequencer iws_sequencer_sva u_sva (.core_clk, .reset, .reg_addr,
   .reg_rd, .reg_rdata, .cpu_boundary, .cpu_global_mask, .cpu_trap_instr,
   .cpu_wait_instr, .cpu_stop_instr, .cpu_entry_done, .any_reset,
   .service_req, .vector_addr, .stack_pc_minus_one, .stack_upper_index,
   .clear_global_mask, .cpu_clk_en, .periph_clk_en);

/* iws_cpu_model.sv */
// processor core model: finishes stacking some cycles after a request
module iws_cpu_model #(
   parameter int DLY = 3
)(
   // clock and reset
   input wire core_clk,
   input wire reset,
   // handshake
   input wire service_req,
   output logic cpu_entry_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   // count stacking cycles, one-cycle done pulse
   always @(posedge core_clk or posedge reset)
      if (reset)
      begin
         cnt_q <= 0;
         cpu_entry_done <= 1'b0;
      end
      else
      begin
         cpu_entry_done <= service_req && cnt_q == DLY;
         cnt_q <= (!service_req || cpu_entry_done) ? 0 : cnt_q + 1;
      end
endmodule // iws_cpu_model

/* tb.sv */
// self-checking bench for the interrupt and wait sequencer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset, reg_wr, reg_rd, cpu_global_mask, entry;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [15:0] src_req, vector_addr;
   logic [6:0] kick;
   logic service_req, pcm1, upper, clr_mask, cpu_clk_en, periph_clk_en;
   logic break_active, watchdog_run, flag_clear_ok;
   int miscompares = 0;
   int n_checks = 0;
   iws_sequencer uut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .src_req, .cpu_boundary(kick[0]),
      .cpu_global_mask, .cpu_trap_instr(kick[1]), .cpu_wait_instr(kick[2]),
      .cpu_stop_instr(kick[3]), .cpu_rti_done(kick[4]),
      .cpu_entry_done(entry), .any_reset(kick[5]), .brk_req(kick[6]),
      .flag_clear_req(1'b0), .flag_clear_ok, .service_req, .vector_addr,
      .stack_pc_minus_one(pcm1), .stack_upper_index(upper),
      .clear_global_mask(clr_mask), .cpu_clk_en, .periph_clk_en,
      .break_active, .watchdog_run);
   iws_cpu_model #(.DLY(3)) u_cpu (.core_clk, .reset, .service_req,
      .cpu_entry_done(entry));
   task automatic chk(input [15:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle pulse on core strobes
   task automatic pulse(input [6:0] k);
      @(posedge core_clk) kick <= k;
      @(posedge core_clk) kick <= 7'h00;
      @(negedge core_clk);
   endtask
   task automatic wr(input [3:0] a, input [7:0] v);
      @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge core_clk) reg_wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rd(input [3:0] a);
      @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge core_clk) reg_rd <= 1'b0;
      @(negedge core_clk) d = reg_rdata;
   endtask
   // wait for a request, judge it, wait for entry to finish
   task automatic serv(input [15:0] vec, input pm);
      int i;
      for (i = 0; i < 10 && service_req !== 1'b1; i++) @(negedge core_clk);
      chk(vector_addr, vec);
      chk(pcm1, pm);
      for (i = 0; i < 20 && service_req !== 1'b0; i++) @(negedge core_clk);
      chk(service_req, 1'b0);
   endtask
   task automatic none;
      repeat (3) @(negedge core_clk);
      chk(service_req, 1'b0);
   endtask
   task automatic t_regs;
      @(posedge core_clk) src_req <= 16'hffff;
      wr(4'h0, 8'h00);
      rd(4'h0);
      chk(d, 8'hf4);
      @(posedge core_clk) src_req <= 16'h8000;
      rd(4'h2);
      chk(d, 8'h01);
      rd(4'hf);
      chk(d, 8'h00);
   endtask
   task automatic t_prio;
      wr(4'h5, 8'hff);
      wr(4'h6, 8'hff);
      @(posedge core_clk) {src_req, cpu_global_mask} <= {16'h8048, 1'b0};
      pulse(7'h01);
      serv(16'hfff6, 1'b1);
      @(posedge core_clk) src_req <= 16'h8040;
      pulse(7'h10);
      serv(16'hfff0, 1'b1);
      @(posedge core_clk) src_req <= 16'h8000;
      pulse(7'h01);
      serv(16'hffde, 1'b1);
   endtask
   task automatic t_mask;
      @(posedge core_clk) {src_req, cpu_global_mask} <= {16'h0008, 1'b1};
      pulse(7'h01);
      none();
      pulse(7'h03);
      serv(16'hfffc, 1'b0);
      @(posedge core_clk) cpu_global_mask <= 1'b0;
      none();
      wr(4'h5, 8'hf7);
      pulse(7'h01);
      none();
      wr(4'h5, 8'hff);
      @(posedge core_clk) src_req <= 16'h0000;
   endtask
   task automatic t_wait;
      pulse(7'h04);
      chk(cpu_clk_en, 1'b0);
      chk(clr_mask, 1'b1);
      chk(periph_clk_en, 1'b1);
      @(posedge core_clk) src_req <= 16'h0008;
      serv(16'hfff6, 1'b1);
      chk(cpu_clk_en, 1'b1);
      @(posedge core_clk) src_req <= 16'h0000;
      pulse(7'h04);
      pulse(7'h40);
      serv(16'hfffc, 1'b0);
      chk(break_active, 1'b1);
      chk(flag_clear_ok, 1'b0);
      rd(4'h4);
      chk(d[1], 1'b1);
      wr(4'h3, 8'h01);
      @(negedge core_clk); // permission follows the control bit a cycle on
      chk(flag_clear_ok, 1'b1);
      wr(4'h3, 8'h00);
      pulse(7'h10);
      chk(break_active, 1'b0);
      @(negedge core_clk);
      chk(flag_clear_ok, 1'b1);
   endtask
   task automatic t_misc;
      wr(4'h7, 8'h01);
      @(negedge core_clk);
      chk(watchdog_run, 1'b0);
      wr(4'h7, 8'h00);
      @(negedge core_clk);
      chk(watchdog_run, 1'b1);
      pulse(7'h08);
      chk(clr_mask, 1'b1);
      pulse(7'h20);
      serv(16'hfffe, 1'b0);
      // break while a hardware service is latched waits its turn
      @(posedge core_clk) src_req <= 16'h0008;
      pulse(7'h01);
      pulse(7'h40);
      serv(16'hfff6, 1'b1);
      serv(16'hfffc, 1'b0);
      @(posedge core_clk) src_req <= 16'h0000;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // main sequence
   initial
   begin
      {reg_wr, reg_rd, kick, reg_addr, reg_wdata, src_req} = '0;
      reset = 1'b1;
      cpu_global_mask = 1'b1;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      t_regs();
      t_prio();
      t_mask();
      t_wait();
      t_misc();
      close_out();
   end
   // watchdog against a hang
   initial
   begin
      #20000;
      miscompares++;
      close_out();
   end
endmodule // tb
